// [acbt_defines.svh]
// Constants for the cell bus transmit block
`ifndef ACBT_DEFINES_SVH
`define ACBT_DEFINES_SVH
`define ACBT_REG_CTRL 8'h00
`define ACBT_REG_RANGE 8'h04
`define ACBT_REG_RESULT 8'h08
`define ACBT_REG_PUSH 8'h0c
`define ACBT_REG_GO 8'h10
`define ACBT_REG_STAT_PORT 8'h14
`define ACBT_REG_STAT_VC 8'h18
`define ACBT_REG_CELL_CNT 8'h1c
`define ACBT_REG_IDLE_CNT 8'h20
`define ACBT_REG_OVF 8'h24
`define ACBT_REG_OVF_MASK 8'h28
`define ACBT_MAP_SEL_BIT 7
`define ACBT_CTL_MULTI 0
`define ACBT_CTL_OCTET 1
`define ACBT_CTL_HEC 2
`define ACBT_CTL_COSET 3
`define ACBT_CTL_PHYSIDE 4
`define ACBT_CTL_W 5
`define ACBT_CTL_RESET 5'h00
`define ACBT_CELL_LEN 6'd53
`define ACBT_HDR_LEN 6'd4
`define ACBT_BUF_LAST 6'd63
`define ACBT_BUF_DEPTH 64
`define ACBT_PORTS 32
`define ACBT_COSET 8'h55
`define ACBT_CRC_POLY 8'h07
`define ACBT_IDLE_HDR 32'h00000001
`define ACBT_VC_HI 27
`define ACBT_VC_LO 4
`define ACBT_ALL_ONES 5'h1f
`define ACBT_CNT_MAX 32'hffffffff
`define ACBT_OVF_CELL 0
`define ACBT_OVF_IDLE 1
`endif

// [acbt_pkg.sv]
// Types for the cell bus transmit block
package acbt_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SELECT = 2'b01,
    ST_SEND = 2'b10
  } acbt_state_t;
endpackage

// [acbt_top.sv]
// Cell bus transmit engine with Wishbone slave and link pin logic
//
// The register offsets and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ps
`include "acbt_defines.svh"
// Notes on behaviour
// R1 - Outgoing data, start and parity change on the link clock rising edge.
// R2 - Parity line carries odd parity over data bits 7 down to 0.
// R3 - Start-of-cell is high exactly while the first cell byte is on the bus.
// R4 - PHY-side multi-PHY: data outputs enabled only after enable was asserted.
// R5 - Address bus is output ATM-side, input PHY-side; bit 4 is MSB.
// R6 - Multi-PHY mode polls PHYs round-robin and reports readiness as status.
// R7 - Each poll pass runs from logical port 0 up to the range value.
// R8 - Logical ports map through a table to the physical address driven.
// R9 - Polled readiness per port is kept in the poll result register.
// R10 - A ready polled PHY raises cell room one link clock after the poll.
// R11 - A loaded cell goes to its chosen port once that port is ready.
// R12 - Header check is a CRC-8 over four header bytes, fresh per cell.
// R13 - Optionally the check byte is XORed with 0x55 before insertion.
// R14 - Check byte follows the header in the next clock, no gap.
// R15 - With insertion on, 52 bytes come from the buffer per cell.
// R16 - Cell mode: send a whole cell with send enable low after cell room.
// R17 - Single-PHY mode drives both address buses all ones.
// R18 - Octet mode: send bytes with send enable low while not full.
// R19 - Octet mode: after full, at most four more bytes before pausing.
// R20 - 32-bit counters of sent and idle cells for one port and VPI/VCI.
// R21 - Reading a counter keeps it; only a write clears it.
// R22 - Each counter has a rollover flag driving a maskable interrupt.
// R23 - Range register is a five-bit zero-based last port index.
// R24 - Octet handshake only in single-PHY; multi-PHY uses cell handshake.
module acbt_top import acbt_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic tx_side_clock_i,
  input wire logic tx_flow_in_i,
  output logic tx_flow_out_o,
  output logic [7:0] tx_byte_bus_o,
  output logic tx_cell_start_o,
  output logic tx_parity_o,
  output logic tx_data_oe_n_o,
  output logic [4:0] tx_phy_select_o,
  input wire logic [4:0] tx_phy_select_i,
  output logic tx_phy_select_oe_n_o,
  output logic [4:0] rx_phy_select_o,
  output logic rx_phy_select_oe_n_o,
  output logic stat_irq_o
);

  // CRC-8 step over one byte, polynomial x^8+x^2+x+1
  function automatic logic [7:0] crc8(input logic [7:0] c,
                                      input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ `ACBT_CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // Odd parity bit for a byte
  function automatic logic odd_par(input logic [7:0] b);
    return ~^b;
  endfunction

  // Byte-lane merge for a write
  function automatic logic [31:0] lane_merge(input logic [31:0] o,
                                             input logic [31:0] n,
                                             input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[i*8 +: 8] = n[i*8 +: 8];
    end
    return r;
  endfunction

  // Link pin synchronisers
  logic clk_s1, clk_s2, clk_s3, fin_s1, fin_s2;
  logic [4:0] psel_s1, psel_s2;
  logic le;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_s1 <= 1'b0;
      clk_s2 <= 1'b0;
      clk_s3 <= 1'b0;
      fin_s1 <= 1'b0;
      fin_s2 <= 1'b0;
      psel_s1 <= 5'h00;
      psel_s2 <= 5'h00;
    end else begin
      clk_s1 <= tx_side_clock_i;
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2;
      fin_s1 <= tx_flow_in_i;
      fin_s2 <= fin_s1;
      psel_s1 <= tx_phy_select_i;
      psel_s2 <= psel_s1;
    end
  end
  assign le = clk_s2 & ~clk_s3; // Link rising edge seen R1

  // Register file state
  logic ack, next_ack, irq, next_irq, cell_ready, next_cell_ready;
  logic [31:0] rdat, next_rdat, cell_cnt, next_cell_cnt;
  logic [31:0] idle_cnt, next_idle_cnt;
  logic [`ACBT_CTL_W-1:0] ctrl, next_ctrl;
  logic [4:0] range, next_range, cell_port, next_cell_port;
  logic [4:0] stat_port, next_stat_port;
  logic [23:0] stat_vc, next_stat_vc;
  logic [1:0] ovf, next_ovf, ovf_mask, next_ovf_mask;
  logic [5:0] wr_ptr, next_wr_ptr;
  logic [4:0] map_tbl [`ACBT_PORTS];
  logic [4:0] next_map_tbl [`ACBT_PORTS];
  logic [7:0] buf_mem [`ACBT_BUF_DEPTH];
  logic [7:0] next_buf_mem [`ACBT_BUF_DEPTH];
  logic wr, rd, hit, idle_hit;
  logic [31:0] hdr, wmask;

  // Link state
  acbt_state_t state, next_state;
  logic [5:0] byte_idx, next_byte_idx;
  logic [7:0] hec, next_hec, data, next_data, lb;
  logic soc, next_soc, par, next_par, enb_n, next_enb_n;
  logic data_oe_n, next_data_oe_n, addr_oe_n, next_addr_oe_n;
  logic rx_oe_n, next_rx_oe_n, cell_sent, next_cell_sent;
  logic [4:0] addr, next_addr, poll_idx, next_poll_idx;
  logic [4:0] poll_prev, next_poll_prev;
  logic poll_valid, next_poll_valid, launch, finish;
  logic [31:0] result, next_result;
  logic mode_multi, mode_phy, mode_octet, mode_hec, mode_coset;

  assign mode_multi = ctrl[`ACBT_CTL_MULTI];
  assign mode_phy = ctrl[`ACBT_CTL_PHYSIDE];
  assign mode_octet = ctrl[`ACBT_CTL_OCTET] & ~mode_multi; // R24
  assign mode_hec = ctrl[`ACBT_CTL_HEC];
  assign mode_coset = ctrl[`ACBT_CTL_COSET];
  assign hdr = {buf_mem[0], buf_mem[1], buf_mem[2], buf_mem[3]};

  // Register file next values: bus slave, cell load, statistics
  always_comb begin
    next_ack = wb_cyc_i & wb_stb_i & ~ack;
    wr = wb_cyc_i & wb_stb_i & wb_we_i & ack;
    rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack;
    next_rdat = rdat;
    next_ctrl = ctrl;
    next_range = range;
    next_stat_port = stat_port;
    next_stat_vc = stat_vc;
    next_ovf_mask = ovf_mask;
    next_wr_ptr = wr_ptr;
    next_cell_port = cell_port;
    next_map_tbl = map_tbl;
    next_buf_mem = buf_mem;
    next_cell_ready = cell_ready & ~cell_sent;
    wmask = lane_merge({8'h00, stat_vc}, wb_dat_i, wb_sel_i);
    if (rd) begin
      next_rdat = 32'h00000000;
      if (wb_adr_i[`ACBT_MAP_SEL_BIT]) begin
        next_rdat[4:0] = map_tbl[wb_adr_i[6:2]];
      end else begin
        unique case (wb_adr_i)
          `ACBT_REG_CTRL: next_rdat = {19'h00000, psel_s2, 3'h0, ctrl};
          `ACBT_REG_RANGE: next_rdat[4:0] = range;
          `ACBT_REG_RESULT: next_rdat = result; // R9
          `ACBT_REG_GO: next_rdat = {26'h0000000, cell_ready, cell_port};
          `ACBT_REG_STAT_PORT: next_rdat[4:0] = stat_port;
          `ACBT_REG_STAT_VC: next_rdat[23:0] = stat_vc;
          `ACBT_REG_CELL_CNT: next_rdat = cell_cnt; // R21
          `ACBT_REG_IDLE_CNT: next_rdat = idle_cnt; // R21
          `ACBT_REG_OVF: next_rdat[1:0] = ovf;
          `ACBT_REG_OVF_MASK: next_rdat[1:0] = ovf_mask;
          default: next_rdat = 32'h00000000;
        endcase
      end
    end
    if (wr && wb_adr_i[`ACBT_MAP_SEL_BIT] && wb_sel_i[0]) begin
      next_map_tbl[wb_adr_i[6:2]] = wb_dat_i[4:0]; // R8
    end
    if (wr && !wb_adr_i[`ACBT_MAP_SEL_BIT]) begin
      unique case (wb_adr_i)
        `ACBT_REG_CTRL: if (wb_sel_i[0]) next_ctrl = wb_dat_i[4:0];
        `ACBT_REG_RANGE: if (wb_sel_i[0]) next_range = wb_dat_i[4:0]; // R23
        `ACBT_REG_PUSH: begin
          if (!cell_ready && wr_ptr != `ACBT_BUF_LAST && wb_sel_i[0]) begin
            next_buf_mem[wr_ptr] = wb_dat_i[7:0];
            next_wr_ptr = wr_ptr + 6'd1;
          end
        end
        `ACBT_REG_GO: begin
          if (!cell_ready && wb_sel_i[0]) begin
            next_cell_ready = 1'b1;
            next_cell_port = wb_dat_i[4:0];
            next_wr_ptr = 6'd0;
          end
        end
        `ACBT_REG_STAT_PORT: if (wb_sel_i[0]) next_stat_port = wb_dat_i[4:0];
        `ACBT_REG_STAT_VC: next_stat_vc = wmask[23:0];
        `ACBT_REG_OVF_MASK: if (wb_sel_i[0]) next_ovf_mask = wb_dat_i[1:0];
        default: next_ctrl = ctrl;
      endcase
    end
    // Statistics for the chosen port and VPI/VCI
    hit = cell_sent && cell_port == stat_port
          && hdr[`ACBT_VC_HI:`ACBT_VC_LO] == stat_vc; // R20
    idle_hit = hit && hdr == `ACBT_IDLE_HDR;
    next_cell_cnt = (wr && wb_adr_i == `ACBT_REG_CELL_CNT)
                    ? 32'h00000000 : cell_cnt; // R21
    next_idle_cnt = (wr && wb_adr_i == `ACBT_REG_IDLE_CNT)
                    ? 32'h00000000 : idle_cnt; // R21
    next_ovf = ovf;
    if (wr && wb_adr_i == `ACBT_REG_OVF && wb_sel_i[0]) begin
      next_ovf = ovf & ~wb_dat_i[1:0];
    end
    if (hit) begin
      next_cell_cnt = next_cell_cnt + 32'h00000001;
      if (cell_cnt == `ACBT_CNT_MAX) next_ovf[`ACBT_OVF_CELL] = 1'b1; // R22
    end
    if (idle_hit) begin
      next_idle_cnt = next_idle_cnt + 32'h00000001;
      if (idle_cnt == `ACBT_CNT_MAX) next_ovf[`ACBT_OVF_IDLE] = 1'b1; // R22
    end
    next_irq = |(ovf & ovf_mask); // R22
  end

  // Register file flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
      rdat <= 32'h00000000;
      ctrl <= `ACBT_CTL_RESET;
      range <= 5'h00;
      stat_port <= 5'h00;
      stat_vc <= 24'h000000;
      ovf <= 2'h0;
      ovf_mask <= 2'h0;
      irq <= 1'b0;
      wr_ptr <= 6'd0;
      cell_ready <= 1'b0;
      cell_port <= 5'h00;
      cell_cnt <= 32'h00000000;
      idle_cnt <= 32'h00000000;
      for (int i = 0; i < `ACBT_PORTS; i++) map_tbl[i] <= 5'h00;
    end else begin
      ack <= next_ack;
      rdat <= next_rdat;
      ctrl <= next_ctrl;
      range <= next_range;
      stat_port <= next_stat_port;
      stat_vc <= next_stat_vc;
      ovf <= next_ovf;
      ovf_mask <= next_ovf_mask;
      irq <= next_irq;
      wr_ptr <= next_wr_ptr;
      cell_ready <= next_cell_ready;
      cell_port <= next_cell_port;
      cell_cnt <= next_cell_cnt;
      idle_cnt <= next_idle_cnt;
      map_tbl <= next_map_tbl;
    end
  end

  // Cell buffer storage, data only
  always_ff @(posedge clk_i) begin
    buf_mem <= next_buf_mem;
  end

  // Link engine next values: polling, selection, byte launch
  always_comb begin
    next_state = state;
    next_byte_idx = byte_idx;
    next_hec = hec;
    next_data = data;
    next_soc = soc;
    next_par = par;
    next_enb_n = enb_n;
    next_addr = addr;
    next_poll_idx = poll_idx;
    next_poll_prev = poll_prev;
    next_poll_valid = poll_valid;
    next_result = result;
    next_cell_sent = 1'b0;
    launch = 1'b0;
    finish = 1'b0;
    next_addr_oe_n = mode_multi & mode_phy; // R5
    next_rx_oe_n = mode_multi; // R17
    next_data_oe_n = (mode_multi & mode_phy)
                     ? (le ? fin_s2 : data_oe_n) : 1'b0; // R4
    // Byte for the current position, check byte inserted after header
    if (byte_idx < `ACBT_HDR_LEN) begin
      lb = buf_mem[byte_idx];
    end else if (mode_hec && byte_idx == `ACBT_HDR_LEN) begin
      lb = hec ^ (mode_coset ? `ACBT_COSET : 8'h00); // R13 R14
    end else if (mode_hec) begin
      lb = buf_mem[byte_idx - 6'd1]; // R15
    end else begin
      lb = buf_mem[byte_idx];
    end
    if (le) begin
      unique case (state)
        ST_IDLE: begin
          next_enb_n = 1'b1;
          next_soc = 1'b0;
          if (mode_multi && !mode_phy) begin
            next_addr = map_tbl[poll_idx]; // R6 R8
            next_poll_prev = poll_idx;
            next_poll_valid = 1'b1;
            if (poll_valid) next_result[poll_prev] = fin_s2; // R9 R10
            next_poll_idx = (poll_idx >= range) ? 5'h00
                            : poll_idx + 5'h01; // R7 R23
            if (cell_ready && result[cell_port]) begin
              next_addr = map_tbl[cell_port]; // R11
              next_state = ST_SELECT;
              next_poll_valid = 1'b0;
            end
          end else begin
            next_addr = `ACBT_ALL_ONES; // R17
            next_poll_valid = 1'b0;
            if (cell_ready && fin_s2 && !mode_phy && !mode_multi) begin
              next_state = ST_SEND; // R16 R18
              launch = 1'b1;
            end
          end
        end
        ST_SELECT: begin
          next_state = ST_SEND;
          launch = 1'b1;
        end
        ST_SEND: begin
          if (byte_idx == `ACBT_CELL_LEN) begin
            finish = 1'b1;
          end else if (mode_octet && !fin_s2) begin
            next_enb_n = 1'b1; // R19
            next_soc = 1'b0;
          end else begin
            launch = 1'b1;
          end
        end
        default: next_state = ST_IDLE;
      endcase
    end
    if (launch) begin
      next_data = lb; // R1
      next_soc = (byte_idx == 6'd0); // R3
      next_par = odd_par(lb); // R2
      next_enb_n = 1'b0; // R16 R18
      next_byte_idx = byte_idx + 6'd1;
      if (byte_idx == 6'd0) next_hec = crc8(8'h00, lb); // R12
      else if (byte_idx < `ACBT_HDR_LEN) next_hec = crc8(hec, lb); // R12
    end
    if (finish) begin
      next_state = ST_IDLE;
      next_byte_idx = 6'd0;
      next_enb_n = 1'b1;
      next_soc = 1'b0;
      next_cell_sent = 1'b1;
      if (mode_multi) next_result[cell_port] = 1'b0;
    end
  end

  // Link engine flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      byte_idx <= 6'd0;
      hec <= 8'h00;
      data <= 8'h00;
      soc <= 1'b0;
      par <= 1'b1;
      enb_n <= 1'b1;
      addr <= `ACBT_ALL_ONES;
      data_oe_n <= 1'b0;
      addr_oe_n <= 1'b0;
      rx_oe_n <= 1'b0;
      poll_idx <= 5'h00;
      poll_prev <= 5'h00;
      poll_valid <= 1'b0;
      result <= 32'h00000000;
      cell_sent <= 1'b0;
    end else begin
      state <= next_state;
      byte_idx <= next_byte_idx;
      hec <= next_hec;
      data <= next_data;
      soc <= next_soc;
      par <= next_par;
      enb_n <= next_enb_n;
      addr <= next_addr;
      data_oe_n <= next_data_oe_n;
      addr_oe_n <= next_addr_oe_n;
      rx_oe_n <= next_rx_oe_n;
      poll_idx <= next_poll_idx;
      poll_prev <= next_poll_prev;
      poll_valid <= next_poll_valid;
      result <= next_result;
      cell_sent <= next_cell_sent;
    end
  end

  // Outputs straight from flops, except the rx address, which is the constant all-ones value
  assign wb_dat_o = rdat;
  assign wb_ack_o = ack;
  assign tx_flow_out_o = enb_n;
  assign tx_byte_bus_o = data;
  assign tx_cell_start_o = soc;
  assign tx_parity_o = par;
  assign tx_data_oe_n_o = data_oe_n;
  assign tx_phy_select_o = addr;
  assign tx_phy_select_oe_n_o = addr_oe_n;
  assign rx_phy_select_o = `ACBT_ALL_ONES;
  assign rx_phy_select_oe_n_o = rx_oe_n;
  assign stat_irq_o = irq;

  // Checks on the link and register behaviour
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [4:0] poll_map;
  logic [7:0] hec_out;
  assign poll_map = map_tbl[poll_idx];
  assign hec_out = hec ^ (mode_coset ? `ACBT_COSET : 8'h00);

  property p_parity;
    tx_parity_o == ~^tx_byte_bus_o;
  endproperty
  a_parity: assert property (p_parity) else $error("parity not odd"); // R2
  property p_soc_first;
    $rose(tx_cell_start_o) |-> byte_idx == 6'd1 && !tx_flow_out_o;
  endproperty
  a_soc_first: assert property (p_soc_first) // R3
    else $error("start flag not on first byte");
  property p_single_addr;
    (le && !mode_multi) |=> tx_phy_select_o == `ACBT_ALL_ONES;
  endproperty
  a_single_addr: assert property (p_single_addr) // R17
    else $error("single mode address not all ones");
  property p_hec;
    (le && state == ST_SEND && byte_idx == `ACBT_HDR_LEN && mode_hec
     && !(mode_octet && !fin_s2)) |=> tx_byte_bus_o == $past(hec_out);
  endproperty
  a_hec: assert property (p_hec) // R13
    else $error("check byte wrong");
  property p_range;
    (le && state == ST_IDLE && mode_multi && !mode_phy
     && poll_idx >= range) |=> poll_idx == 5'h00;
  endproperty
  a_range: assert property (p_range) else $error("poll did not wrap"); // R7
  property p_map;
    (le && state == ST_IDLE && mode_multi && !mode_phy
     && !(cell_ready && result[cell_port]))
    |=> tx_phy_select_o == $past(poll_map);
  endproperty
  a_map: assert property (p_map) else $error("poll address not mapped"); // R8
  property p_result;
    (le && state == ST_IDLE && mode_multi && !mode_phy && poll_valid)
    |=> result[$past(poll_prev)] == $past(fin_s2);
  endproperty
  a_result: assert property (p_result) // R9
    else $error("poll result not stored");
  property p_oe;
    (mode_multi && mode_phy && le && fin_s2) |=> tx_data_oe_n_o;
  endproperty
  a_oe: assert property (p_oe) else $error("outputs enabled early"); // R4
  property p_octet;
    (le && state == ST_SEND && mode_octet && !fin_s2) |=> tx_flow_out_o;
  endproperty
  a_octet: assert property (p_octet) // R19
    else $error("octet mode did not pause");
  property p_keep;
    (!cell_sent && !(wr && wb_adr_i == `ACBT_REG_CELL_CNT))
    |=> $stable(cell_cnt);
  endproperty
  a_keep: assert property (p_keep) else $error("counter changed"); // R21
  property p_roll;
    (hit && cell_cnt == `ACBT_CNT_MAX) |=> ovf[`ACBT_OVF_CELL] ##1
      (stat_irq_o == ovf_mask[`ACBT_OVF_CELL] || !ovf[`ACBT_OVF_CELL]);
  endproperty
  a_roll: assert property (p_roll) else $error("rollover not flagged"); // R22
  property p_ack;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack held too long");

  c_sent: cover property (cell_sent && mode_hec);
  c_multi: cover property (state == ST_SELECT ##[1:60] tx_cell_start_o);
  c_pause: cover property (le && state == ST_SEND && mode_octet && !fin_s2);
  c_roll: cover property (ovf[`ACBT_OVF_CELL]);

endmodule // acbt_top

// [acbt_phy.sv]
// Behavioural PHY on the far side of the transmit link
`timescale 1ns/1ps
module acbt_phy (
  input wire logic lk_i,
  input wire logic clr_i,
  input wire logic multi_i,
  input wire logic room_i,
  input wire logic [31:0] map_i,
  input wire logic en_n_i,
  input wire logic soc_i,
  input wire logic par_i,
  input wire logic [7:0] d_i,
  input wire logic [4:0] a_i,
  output logic flow_o,
  output logic [7:0] got_o [0:52],
  output int n_o,
  output int bad_o,
  output logic [31:0] seen_o,
  output logic [4:0] sa_o
);
  int p;
  // Quiet state at time zero
  initial begin
    flow_o = 1'b0;
    n_o = 0;
    bad_o = 0;
    seen_o = '0;
    sa_o = '0;
    p = 0;
  end
  // Room answer and byte capture on each link rising edge
  always @(posedge lk_i) begin
    flow_o <= multi_i ? map_i[a_i] : room_i;
    if (clr_i) begin
      n_o <= 0;
      seen_o <= '0;
    end else begin
      if (multi_i && en_n_i) seen_o[a_i] <= 1'b1;
      if (!en_n_i) begin
        p = soc_i ? 0 : p + 1;
        if (soc_i) sa_o <= a_i;
        if (p < 53) got_o[p] <= d_i;
        // Odd parity and start flag on the first byte of each cell
        if (^{d_i, par_i} !== 1'b1 || soc_i !== (n_o % 53 == 0))
          bad_o <= bad_o + 1;
        n_o <= n_o + 1;
      end
    end
  end
endmodule // acbt_phy

// [acbt_top_bench.sv]
// Self-checking bench for the cell bus transmit block
`timescale 1ns/1ps
`include "acbt_defines.svh"
module acbt_top_bench import acbt_pkg::*; ;
  logic clk_i = 1'b0, rst_i = 1'b1, lk = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic wb_ack_o, tx_flow_in_i, tx_flow_out_o, tx_cell_start_o, tx_parity_o;
  logic [7:0] tx_byte_bus_o;
  logic [4:0] tx_phy_select_o, rx_phy_select_o, sa, psel = 5'h00;
  logic tx_data_oe_n_o, tx_phy_select_oe_n_o, rx_phy_select_oe_n_o;
  logic stat_irq_o, clr = 1'b0, multi = 1'b0, room = 1'b0;
  logic [31:0] rmap = '0, hdr = 32'h0a1b2c3d, seen;
  logic [7:0] got [0:52];
  int n, pbad, bad_count = 0, n_tests = 0;
  // Clocks of the two domains
  always #5 clk_i = ~clk_i;
  always #62.5 lk = ~lk;
  acbt_top dut (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .tx_side_clock_i(lk), .tx_flow_in_i,
    .tx_flow_out_o, .tx_byte_bus_o, .tx_cell_start_o, .tx_parity_o,
    .tx_data_oe_n_o, .tx_phy_select_o, .tx_phy_select_i(psel),
    .tx_phy_select_oe_n_o, .rx_phy_select_o, .rx_phy_select_oe_n_o,
    .stat_irq_o
  );
  acbt_phy phy (
    .lk_i(lk), .clr_i(clr), .multi_i(multi), .room_i(room), .map_i(rmap),
    .en_n_i(tx_flow_out_o), .soc_i(tx_cell_start_o), .par_i(tx_parity_o),
    .d_i(tx_byte_bus_o), .a_i(tx_phy_select_o), .flow_o(tx_flow_in_i),
    .got_o(got), .n_o(n), .bad_o(pbad), .seen_o(seen), .sa_o(sa)
  );
  task automatic conclude();
    if (bad_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input string s, input logic [31:0] e,
                       input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  // One classic bus cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int t;
    t = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 50);
    q = wb_dat_o;
    if (t >= 50) check("bus ack", 1, 0);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rdc(input string s, input logic [7:0] a,
                     input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    check(s, e, q);
  endtask
  function automatic logic [7:0] crc8(input logic [31:0] h);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 31; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ h[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  task automatic clear();
    clr <= 1'b1;
    repeat (30) @(posedge clk_i);
    clr <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic idle_wait();
    logic [31:0] q;
    q = 32'h20;
    while (q[5] !== 1'b0) wb(1'b0, `ACBT_REG_GO, 32'h0, q);
  endtask
  task automatic wait_n(input int k);
    int t;
    t = 0;
    while (n < k && t < 2000) begin
      @(posedge clk_i);
      t++;
    end
    check("bytes sent", k, n);
  endtask
  task automatic load(input logic [4:0] port, input int len);
    idle_wait();
    for (int k = 0; k < len; k++)
      wr(`ACBT_REG_PUSH, k < 4 ? {24'h0, hdr[31 - 8 * k -: 8]} : 32'(k));
    wr(`ACBT_REG_GO, {27'h0, port});
  endtask
  task automatic t_reset();
    @(posedge clk_i);
    check("send enable", 1, tx_flow_out_o);
    check("tx address", 32'h1f, tx_phy_select_o);
    check("rx address", 32'h1f, rx_phy_select_o);
    rdc("control", `ACBT_REG_CTRL, 32'h0);
    rdc("unmapped", 8'h40, 32'h0);
  endtask
  task automatic t_single(input logic hec, input logic cos);
    logic [7:0] e;
    wr(`ACBT_REG_CTRL, {28'h0, cos, hec, 2'b00});
    clear();
    load(5'h00, hec ? 52 : 53);
    wait_n(53);
    for (int j = 0; j < 53; j++) begin
      if (j < 4) e = hdr[31 - 8 * j -: 8];
      else if (hec && j == 4) e = crc8(hdr) ^ (cos ? `ACBT_COSET : 8'h00);
      else e = 8'(hec ? j - 1 : j);
      check("cell byte", e, got[j]);
    end
  endtask
  task automatic t_stats();
    wr(`ACBT_REG_STAT_PORT, 32'h0);
    wr(`ACBT_REG_STAT_VC, {8'h00, hdr[`ACBT_VC_HI:`ACBT_VC_LO]});
    t_single(1'b0, 1'b0);
    t_single(1'b1, 1'b0);
    t_single(1'b1, 1'b1);
    idle_wait();
    rdc("cell count", `ACBT_REG_CELL_CNT, 32'h3);
    rdc("cell count", `ACBT_REG_CELL_CNT, 32'h3);
    rdc("idle count", `ACBT_REG_IDLE_CNT, 32'h0);
    wr(`ACBT_REG_CELL_CNT, 32'h0);
    rdc("cell count", `ACBT_REG_CELL_CNT, 32'h0);
    // One idle cell through the same port filter, with the VPI/VCI filter set to zero
    hdr = `ACBT_IDLE_HDR;
    wr(`ACBT_REG_STAT_VC, 32'h0);
    t_single(1'b0, 1'b0);
    idle_wait();
    rdc("idle count", `ACBT_REG_IDLE_CNT, 32'h1);
    rdc("cell count", `ACBT_REG_CELL_CNT, 32'h1);
  endtask
  task automatic t_octet();
    int n0;
    wr(`ACBT_REG_CTRL, 32'h2);
    room <= 1'b0;
    clear();
    load(5'h00, 53);
    repeat (300) @(posedge clk_i);
    check("bytes while full", 0, n);
    room <= 1'b1;
    while (n < 10) @(posedge clk_i);
    room <= 1'b0;
    n0 = n;
    repeat (300) @(posedge clk_i);
    check("bytes after full", 1, n - n0 <= 4);
    check("send enable", 1, tx_flow_out_o);
    room <= 1'b1;
    wait_n(53);
  endtask
  task automatic t_multi();
    logic [4:0] pm [0:4];
    logic [31:0] e;
    pm = '{5'h03, 5'h05, 5'h07, 5'h09, 5'h16};
    e = '0;
    multi <= 1'b1;
    rmap <= 32'h00400020;
    wr(`ACBT_REG_CTRL, 32'h1);
    for (int i = 0; i < 5; i++) begin
      wr(8'h80 + 8'(4 * i), {27'h0, pm[i]});
      e[pm[i]] = 1'b1;
    end
    wr(`ACBT_REG_RANGE, 32'h4);
    clear();
    repeat (300) @(posedge clk_i);
    check("polled addresses", e, seen);
    rdc("poll result", `ACBT_REG_RESULT, 32'h12);
    clear();
    load(5'h04, 53);
    wait_n(53);
    check("cell address", 32'h16, sa);
    check("parity or start faults", 0, pbad);
  endtask
  // PHY-side mode: address bus as input, data drive follows enable
  task automatic t_physide();
    psel <= 5'h0a;
    rmap <= 32'h0;
    wr(`ACBT_REG_CTRL, 32'h11);
    repeat (40) @(posedge clk_i);
    check("address drive", 1, tx_phy_select_oe_n_o);
    check("data drive", 0, tx_data_oe_n_o);
    rdc("control", `ACBT_REG_CTRL, 32'h00000a11);
    rmap <= 32'h80000000;
    repeat (40) @(posedge clk_i);
    check("data drive", 1, tx_data_oe_n_o);
  endtask
  // Reset, then the scenarios in turn
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    room <= 1'b1;
    t_reset();
    t_stats();
    t_octet();
    t_multi();
    t_physide();
    conclude();
  end
  // Watchdog against a hang
  initial begin
    repeat (30000) @(posedge clk_i);
    bad_count++;
    conclude();
  end
endmodule // acbt_top_bench
